/* core/bmp_crc16.sv */
`timescale 1ns/10ps
`default_nettype none
module bmp_crc16 (
  input  wire logic [15:0] i_crc,
  input  wire logic [7:0]  i_byte,
  output logic      [15:0] o_crc
);
  // One byte of MSB-first CRC per call, unrolled by generate
  logic [15:0] stage [0:8];
  assign stage[0] = i_crc;
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic fb;
      assign fb = stage[b][15] ^ i_byte[7-b];
      assign stage[b+1] = {stage[b][14:0], 1'b0} ^ (fb ? bmp_pkg::CRC_POLY : 16'h0000);
    end
  endgenerate
  assign o_crc = stage[8];
endmodule // bmp_crc16
`default_nettype wire

/* core/bmp_engine.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Extended layout: metadata bytes follow each block's data in one stream.
// - Layout is namespace format state; changes only while idle.
// - Extended layout moves data and metadata through the data pointer stream.
// - Separate layout tags metadata for the metadata pointer stream.
// - One layout per namespace; no mixing within a transfer.
// - Protection info lives inside each block's metadata when enabled.
// - Protection info is the first or last eight metadata bytes.
// - Leading placement: guard covers block data only.
// - Types one, two, three selectable at format, readable back.
// - Guard is a 16-bit CRC over block data.
// - No IP checksum guard option exists.
// - Application tag is opaque except the escape value.
// - Reference tag binds block to address; escape value disables checks.
// - Check bits 2,1,0 enable guard, masked app tag, ref tag checks.
// - Expected ref tag starts at initial value, increments per block.
// - App tag all ones skips checks; type three also needs ref all ones.
// - Insert fills guard with CRC, app tag, computed ref tag.
module bmp_engine (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // Input byte stream
  input  wire bmp_pkg::bmp_beat_type i_in,
  output logic                       o_in_ready,
  // Output byte stream
  output bmp_pkg::bmp_beat_type      o_out,
  output logic                       o_busy,
  output bmp_pkg::bmp_err_type       o_err
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    bmp_pkg::bmp_format_type fmt;
    bmp_pkg::bmp_cmd_type    cmd;
    bmp_pkg::bmp_state_type  st;
    logic [11:0]             cnt;
    logic [15:0]             blk;
    logic [15:0]             crc;
    logic [31:0]             ref_tag;
    logic [63:0]             pi;
    logic [15:0]             last_guard;
    bmp_pkg::bmp_err_type    err;
    bmp_pkg::bmp_beat_type   out;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    busy;
  } bmp_state_all_type;

  bmp_state_all_type s_reg;
  bmp_state_all_type s_next;
  logic [15:0]       crc_step;
  logic              pi_zone;
  logic [3:0]        pi_idx;
  logic [11:0]       pi_start;
  logic              in_take;
  logic [63:0]       pi_now;
  logic              skip;
  logic [15:0]       ins_byte_sel;

  ////////////////////////////////////////////////////////////////////////
  // Byte-serial guard CRC
  bmp_crc16 u_crc (
    .i_crc  (s_reg.crc),
    .i_byte (i_in.data),
    .o_crc  (crc_step)
  );

  // Where the protection field sits inside metadata
  // Needs at least eight metadata bytes whenever protection is on
  always_comb begin
    pi_start = s_reg.fmt.pi_first ? 12'h000 : s_reg.fmt.meta_len - 12'(bmp_pkg::PI_BYTES);
    pi_zone  = s_reg.fmt.pi_en && (s_reg.st == bmp_pkg::BMP_META)
               && (s_reg.cnt >= pi_start) && (s_reg.cnt < pi_start + 12'(bmp_pkg::PI_BYTES));
    pi_idx   = 4'(s_reg.cnt - pi_start);
  end

  // Accept input only while a command runs; stalls outside frames
  assign in_take    = i_in.valid && (s_reg.st != bmp_pkg::BMP_IDLE);
  assign o_in_ready = s_reg.busy;

  // Protection field including the byte arriving now
  always_comb begin
    pi_now = s_reg.pi;
    if (pi_zone) begin
      pi_now[8'(63 - 8 * pi_idx) -: 8] = i_in.data;
    end
  end

  // Escape values switch all checks off
  always_comb begin
    skip = (pi_now[47:32] == bmp_pkg::APP_TAG_ESC);
    if (s_reg.fmt.pi_type == bmp_pkg::BMP_PI_TYPE3) begin
      skip = skip && (pi_now[31:0] == bmp_pkg::REF_TAG_ESC);
    end
  end

  // Inserted field: guard, app tag, computed ref tag
  always_comb begin
    case (pi_idx)
      4'h0:    ins_byte_sel = {8'h00, s_reg.crc[15:8]};
      4'h1:    ins_byte_sel = {8'h00, s_reg.crc[7:0]};
      4'h2:    ins_byte_sel = {8'h00, s_reg.cmd.expected_app_tag[15:8]};
      4'h3:    ins_byte_sel = {8'h00, s_reg.cmd.expected_app_tag[7:0]};
      4'h4:    ins_byte_sel = {8'h00, s_reg.ref_tag[31:24]};
      4'h5:    ins_byte_sel = {8'h00, s_reg.ref_tag[23:16]};
      4'h6:    ins_byte_sel = {8'h00, s_reg.ref_tag[15:8]};
      default: ins_byte_sel = {8'h00, s_reg.ref_tag[7:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: APB, stream sequencer, checker
  always_comb begin
    s_next         = s_reg;
    s_next.out     = '0;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;

    // APB: no wait states, answer in the cycle after setup
    if (i_psel && !i_penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (i_paddr)
        bmp_pkg::OFS_FORMAT:     s_next.prdata = {s_reg.fmt.meta_len, s_reg.fmt.data_len,
                                                  3'b000, s_reg.fmt.separate, s_reg.fmt.pi_first,
                                                  s_reg.fmt.pi_type, s_reg.fmt.pi_en};
        bmp_pkg::OFS_CMD:        s_next.prdata = {27'h0, s_reg.cmd.is_write,
                                                  s_reg.cmd.insert_strip_select,
                                                  s_reg.cmd.check_select_bits};
        bmp_pkg::OFS_APP_TAG:    s_next.prdata = {s_reg.cmd.app_tag_compare_mask,
                                                  s_reg.cmd.expected_app_tag};
        bmp_pkg::OFS_REF_TAG:    s_next.prdata = s_reg.cmd.initial_ref_tag;
        bmp_pkg::OFS_BLKCNT:     s_next.prdata = {s_reg.blk, s_reg.cmd.block_count};
        bmp_pkg::OFS_STATUS:     s_next.prdata = {28'h0, (s_reg.st != bmp_pkg::BMP_IDLE),
                                                  s_reg.err};
        bmp_pkg::OFS_LAST_GUARD: s_next.prdata = {16'h0, s_reg.last_guard};
        default:                 s_next.pslverr = 1'b1;
      endcase
    end

    // APB writes take effect at the access edge; format only while idle
    if (i_psel && i_penable && s_reg.pready && i_pwrite && !s_reg.pslverr) begin
      // Busy-time format and command writes are dropped with no error; software polls busy first
      case (i_paddr)
        bmp_pkg::OFS_FORMAT: begin
          if (s_reg.st == bmp_pkg::BMP_IDLE) begin
            s_next.fmt.pi_en    = i_pwdata[bmp_pkg::FMT_PI_EN];
            s_next.fmt.pi_type  = bmp_pkg::bmp_pi_type_type'(i_pwdata[bmp_pkg::FMT_TYPE_LO +: 2]);
            s_next.fmt.pi_first = i_pwdata[bmp_pkg::FMT_PI_FIRST];
            s_next.fmt.separate = i_pwdata[bmp_pkg::FMT_SEPARATE];
            s_next.fmt.data_len = i_pwdata[bmp_pkg::FMT_DLEN_LO +: 12];
            s_next.fmt.meta_len = i_pwdata[bmp_pkg::FMT_MLEN_LO +: 12];
          end
        end
        bmp_pkg::OFS_CMD: begin
          if (s_reg.st == bmp_pkg::BMP_IDLE) begin
            s_next.cmd.check_select_bits   = i_pwdata[bmp_pkg::CMD_CHK_LO +: 3];
            s_next.cmd.insert_strip_select = i_pwdata[bmp_pkg::CMD_INSERT];
            s_next.cmd.is_write            = i_pwdata[bmp_pkg::CMD_WRITE];
            if (i_pwdata[bmp_pkg::CMD_START] && s_reg.cmd.block_count != 16'h0000) begin
              s_next.st      = bmp_pkg::BMP_DATA;
              s_next.cnt     = '0;
              s_next.blk     = '0;
              s_next.crc     = bmp_pkg::CRC_SEED;
              s_next.ref_tag = s_reg.cmd.initial_ref_tag;
              s_next.err     = '0;
            end
          end
        end
        bmp_pkg::OFS_APP_TAG: begin
          s_next.cmd.expected_app_tag     = i_pwdata[15:0];
          s_next.cmd.app_tag_compare_mask = i_pwdata[31:16];
        end
        bmp_pkg::OFS_REF_TAG: s_next.cmd.initial_ref_tag = i_pwdata;
        bmp_pkg::OFS_BLKCNT:  s_next.cmd.block_count = i_pwdata[15:0];
        default: ;
      endcase
    end

    // Stream sequencer: data bytes then metadata bytes of each block
    if (in_take) begin
      s_next.out.valid   = 1'b1;
      s_next.out.data    = i_in.data;
      s_next.out.is_meta = (s_reg.st == bmp_pkg::BMP_META) && s_reg.fmt.separate;
      s_next.cnt         = s_reg.cnt + 12'h001;
      // No strip on reads: read bytes pass through as they arrive
      case (s_reg.st)
        bmp_pkg::BMP_DATA: begin
          s_next.crc = crc_step;
          if (s_reg.cnt == s_reg.fmt.data_len - 12'h001) begin
            s_next.cnt = '0;
            s_next.st  = (s_reg.fmt.meta_len != 12'h000) ? bmp_pkg::BMP_META : bmp_pkg::BMP_DATA;
          end
        end
        bmp_pkg::BMP_META: begin
          if (!pi_zone && !s_reg.fmt.pi_first && s_reg.cnt < pi_start) begin
            s_next.crc = crc_step;
          end
          // Leading placement leaves metadata out of the guard
          if (pi_zone) begin
            s_next.pi = pi_now;
            if (s_reg.cmd.insert_strip_select && s_reg.cmd.is_write) begin
              s_next.out.data = ins_byte_sel[7:0];
            end
          end
          if (pi_zone && pi_idx == 4'(bmp_pkg::PI_BYTES - 1) &&
              !(s_reg.cmd.insert_strip_select && s_reg.cmd.is_write) && !skip) begin
            if (s_reg.cmd.check_select_bits[bmp_pkg::CHK_GUARD_BIT] &&
                pi_now[63:48] != s_reg.crc) begin
              s_next.err.guard_err = 1'b1;
            end
            if (s_reg.cmd.check_select_bits[bmp_pkg::CHK_APP_BIT] &&
                ((pi_now[47:32] ^ s_reg.cmd.expected_app_tag) &
                 s_reg.cmd.app_tag_compare_mask) != 16'h0000) begin
              s_next.err.app_err = 1'b1;
            end
            if (s_reg.cmd.check_select_bits[bmp_pkg::CHK_REF_BIT] &&
                pi_now[31:0] != s_reg.ref_tag) begin
              s_next.err.ref_err = 1'b1;
            end
          end
          if (s_reg.cnt == s_reg.fmt.meta_len - 12'h001) begin
            s_next.cnt        = '0;
            s_next.crc        = bmp_pkg::CRC_SEED;
            s_next.last_guard = s_reg.crc;
            s_next.ref_tag    = s_reg.ref_tag + 32'h0000_0001;
            s_next.blk        = s_reg.blk + 16'h0001;
            s_next.st         = bmp_pkg::BMP_DATA;
            s_next.out.last   = (s_reg.blk == s_reg.cmd.block_count - 16'h0001);
            if (s_next.out.last) begin
              s_next.st = bmp_pkg::BMP_IDLE;
            end
          end
        end
        default: s_next.st = bmp_pkg::BMP_IDLE;
      endcase
      // Blocks with no metadata end on their last data byte
      if (s_reg.st == bmp_pkg::BMP_DATA && s_reg.fmt.meta_len == 12'h000 &&
          s_reg.cnt == s_reg.fmt.data_len - 12'h001) begin
        s_next.crc      = bmp_pkg::CRC_SEED;
        s_next.blk      = s_reg.blk + 16'h0001;
        s_next.ref_tag  = s_reg.ref_tag + 32'h0000_0001;
        s_next.out.last = (s_reg.blk == s_reg.cmd.block_count - 16'h0001);
        if (s_next.out.last) begin
          s_next.st = bmp_pkg::BMP_IDLE;
        end
      end
    end
    // Busy kept as its own flop so status outputs need no decode
    s_next.busy = (s_next.st != bmp_pkg::BMP_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output straight from the state register
  assign o_prdata  = s_reg.prdata;
  assign o_pready  = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_out     = s_reg.out;
  assign o_err     = s_reg.err;
  assign o_busy    = s_reg.busy;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_ref_tag_step: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (s_reg.st == bmp_pkg::BMP_META && in_take && s_reg.cnt == s_reg.fmt.meta_len - 12'h001)
    |=> s_reg.ref_tag == $past(s_reg.ref_tag) + 32'h0000_0001)
    else $error("ref tag did not step");
  a_format_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (s_reg.st != bmp_pkg::BMP_IDLE) |=> $stable(s_reg.fmt))
    else $error("format changed mid command");
  a_skip_no_err: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (pi_zone && in_take && skip && s_reg.err == '0) |=> s_reg.err == '0)
    else $error("escape block flagged");
  a_guard_cover: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && s_reg.fmt.pi_first && pi_idx != 4'(bmp_pkg::PI_BYTES - 1))
    |=> $stable(s_reg.crc))
    else $error("guard covered metadata");
  a_app_mask: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && s_reg.cmd.app_tag_compare_mask == 16'h0000 && !s_reg.err.app_err)
    |=> !s_reg.err.app_err)
    else $error("masked app tag flagged");
  a_insert_guard: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && pi_idx == 4'h0 && s_reg.cmd.insert_strip_select && s_reg.cmd.is_write)
    |=> o_out.data == $past(s_reg.crc[15:8]))
    else $error("inserted guard wrong");
  a_meta_route: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && s_reg.st == bmp_pkg::BMP_DATA) |=> !o_out.is_meta)
    else $error("data routed as metadata");
  a_echo_out: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    in_take |=> o_out.valid)
    else $error("beat lost");
  // Checks that must fire on the last protection byte of a block, then insert, reseed, end-of-command and APB checks
  a_guard_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && pi_idx == 4'(bmp_pkg::PI_BYTES - 1) && !skip
     && !(s_reg.cmd.insert_strip_select && s_reg.cmd.is_write)
     && s_reg.cmd.check_select_bits[bmp_pkg::CHK_GUARD_BIT] && pi_now[63:48] != s_reg.crc)
    |=> o_err.guard_err)
    else $error("guard mismatch not flagged");
  a_ref_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && pi_idx == 4'(bmp_pkg::PI_BYTES - 1) && !skip
     && !(s_reg.cmd.insert_strip_select && s_reg.cmd.is_write)
     && s_reg.cmd.check_select_bits[bmp_pkg::CHK_REF_BIT] && pi_now[31:0] != s_reg.ref_tag)
    |=> o_err.ref_err)
    else $error("ref tag mismatch not flagged");
  a_insert_app: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && pi_zone && pi_idx == 4'h2 && s_reg.cmd.insert_strip_select && s_reg.cmd.is_write)
    |=> o_out.data == $past(s_reg.cmd.expected_app_tag[15:8]))
    else $error("inserted app tag wrong");
  a_seed_block: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (in_take && s_reg.st == bmp_pkg::BMP_META && s_reg.cnt == s_reg.fmt.meta_len - 12'h001)
    |=> s_reg.crc == bmp_pkg::CRC_SEED)
    else $error("guard not reseeded");
  a_last_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_out.last |-> !o_busy)
    else $error("busy after last byte");
  a_apb_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_psel && !i_penable) |=> o_pready)
    else $error("no answer after setup");
  a_unmapped_err: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_psel && !i_penable && i_paddr > bmp_pkg::OFS_LAST_GUARD) |=> o_pslverr)
    else $error("unmapped access not refused");
endmodule // bmp_engine
`default_nettype wire

/* include/bmp_pkg.sv */
package bmp_pkg;
  // Protection information field size, block count and length widths
  localparam int unsigned PI_BYTES      = 8;
  localparam int unsigned BLK_CNT_W     = 16;
  localparam int unsigned LEN_W         = 16;

  // Guard polynomial, zero seed, no reflection, no final inversion
  localparam logic [15:0] CRC_POLY      = 16'h8BB7;
  localparam logic [15:0] CRC_SEED      = 16'h0000;
  localparam logic [15:0] APP_TAG_ESC   = 16'hFFFF;
  localparam logic [31:0] REF_TAG_ESC   = 32'hFFFF_FFFF;

  // Check select bit positions
  localparam int unsigned CHK_GUARD_BIT = 2;
  localparam int unsigned CHK_APP_BIT   = 1;
  localparam int unsigned CHK_REF_BIT   = 0;

  // APB register offsets (byte addresses)
  localparam logic [7:0] OFS_FORMAT     = 8'h00;
  localparam logic [7:0] OFS_CMD        = 8'h04;
  localparam logic [7:0] OFS_APP_TAG    = 8'h08;
  localparam logic [7:0] OFS_REF_TAG    = 8'h0C;
  localparam logic [7:0] OFS_BLKCNT     = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_LAST_GUARD = 8'h18;

  // Format register field positions
  localparam int unsigned FMT_PI_EN     = 0;
  localparam int unsigned FMT_TYPE_LO   = 1;
  localparam int unsigned FMT_PI_FIRST  = 3;
  localparam int unsigned FMT_SEPARATE  = 4;
  localparam int unsigned FMT_DLEN_LO   = 8;
  localparam int unsigned FMT_MLEN_LO   = 20;
  // Command register field positions
  localparam int unsigned CMD_CHK_LO    = 0;
  localparam int unsigned CMD_INSERT    = 3;
  localparam int unsigned CMD_WRITE     = 4;
  localparam int unsigned CMD_START     = 8;

  typedef enum logic [1:0] {
    BMP_PI_NONE  = 2'b00,
    BMP_PI_TYPE1 = 2'b01,
    BMP_PI_TYPE2 = 2'b10,
    BMP_PI_TYPE3 = 2'b11
  } bmp_pi_type_type;

  typedef enum logic [1:0] {
    BMP_IDLE = 2'b00,
    BMP_DATA = 2'b01,
    BMP_META = 2'b10
  } bmp_state_type;

  // Namespace format, fixed at format time
  typedef struct packed {
    logic            pi_en;
    bmp_pi_type_type pi_type;
    logic            pi_first;
    logic            separate;
    logic [11:0]     data_len;
    logic [11:0]     meta_len;
  } bmp_format_type;

  // Per command parameters
  typedef struct packed {
    logic [2:0]  check_select_bits;
    logic        insert_strip_select;
    logic        is_write;
    logic [15:0] expected_app_tag;
    logic [15:0] app_tag_compare_mask;
    logic [31:0] initial_ref_tag;
    logic [15:0] block_count;
  } bmp_cmd_type;

  // Byte stream beat
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       is_meta;
    logic       last;
  } bmp_beat_type;

  typedef struct packed {
    logic guard_err;
    logic app_err;
    logic ref_err;
  } bmp_err_type;
endpackage

/* testbench/block_metadata_protection_info_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module block_metadata_protection_info_tb;
  typedef struct packed {
    logic [1:0]  ty;
    logic        first;
    logic        sep;
    logic [11:0] ml;
    logic [2:0]  chk;
    logic [15:0] mask;
    logic [15:0] app;
    logic        gbad;
    logic [1:0]  rsel;
    logic [2:0]  exp;
  } bmp_row_type;

  localparam logic [31:0] REF0 = 32'h0000_0100;
  localparam int          NR   = 11;
  logic                  clk, rstn, psel, penable, pwrite, pslverr, pready;
  logic                  in_ready, busy, go, slow, rerr;
  logic [7:0]            paddr, len, got;
  logic [31:0]           pwdata, prdata, rd;
  bmp_pkg::bmp_beat_type in_beat, out_beat;
  bmp_pkg::bmp_err_type  err;
  logic [7:0]            expb [0:63];
  logic                  expm [0:63];
  logic [15:0]           g_last;
  int                    n_errors = 0;
  int                    n_checks = 0;
  // Block format, checks, tags, escapes; expected sticky errors
  bmp_row_type rows [0:NR-1] = '{
    '{2'd1, 1'b1, 1'b0, 12'd8,  3'd7, 16'hFFFF, 16'h1234, 1'b0, 2'd0, 3'b000},
    '{2'd1, 1'b1, 1'b0, 12'd12, 3'd4, 16'hFFFF, 16'h1234, 1'b1, 2'd0, 3'b100},
    '{2'd1, 1'b0, 1'b1, 12'd12, 3'd4, 16'hFFFF, 16'h1234, 1'b0, 2'd0, 3'b000},
    '{2'd2, 1'b1, 1'b0, 12'd8,  3'd2, 16'hFFFF, 16'h1235, 1'b0, 2'd0, 3'b010},
    '{2'd2, 1'b1, 1'b1, 12'd8,  3'd2, 16'h00FF, 16'h5634, 1'b0, 2'd0, 3'b000},
    '{2'd2, 1'b1, 1'b0, 12'd8,  3'd1, 16'hFFFF, 16'h1234, 1'b0, 2'd1, 3'b001},
    '{2'd1, 1'b1, 1'b0, 12'd8,  3'd7, 16'hFFFF, 16'hFFFF, 1'b1, 2'd1, 3'b000},
    '{2'd3, 1'b1, 1'b0, 12'd8,  3'd7, 16'hFFFF, 16'hFFFF, 1'b1, 2'd1, 3'b111},
    '{2'd3, 1'b0, 1'b0, 12'd8,  3'd7, 16'hFFFF, 16'hFFFF, 1'b1, 2'd2, 3'b000},
    '{2'd1, 1'b1, 1'b0, 12'd8,  3'd0, 16'hFFFF, 16'h0000, 1'b1, 2'd1, 3'b000},
    '{2'd1, 1'b1, 1'b0, 12'd8,  3'd2, 16'h0000, 16'h5678, 1'b0, 2'd0, 3'b000}};

  bmp_engine dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_in(in_beat), .o_in_ready(in_ready),
    .o_out(out_beat), .o_busy(busy), .o_err(err));
  bmp_host_model pm (.i_ref_clk(clk), .i_rstn(rstn), .i_go(go), .i_slow(slow),
    .i_len(len), .i_in_ready(in_ready), .i_out(out_beat), .o_beat(in_beat), .o_got(got));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bitwise guard reference, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c  = {c[14:0], 1'b0} ^ (fb ? bmp_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // APB master; one idle cycle after each transfer keeps drives single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    check("pready", 32'd1, {31'd0, pready});
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Two blocks of 8 data bytes; insert sends inverted PI and expects the true one
  task automatic build(input bmp_row_type r, input logic ins);
    int          p;
    int          q;
    logic [15:0] g;
    logic [31:0] rf;
    logic [63:0] pi;
    for (int b = 0; b < 2; b++) begin
      p = b * (8 + r.ml);
      g = bmp_pkg::CRC_SEED;
      for (int i = 0; i < 8 + r.ml; i++) begin
        pm.mem[p+i] = 8'(b * 29 + i * 7 + 3);
        expb[p+i]   = pm.mem[p+i];
        expm[p+i]   = (i >= 8);
      end
      q  = r.first ? p + 8 : p + r.ml;
      for (int i = p; i < q; i++) g = crc_byte(g, pm.mem[i]);
      g_last = g;
      rf = (r.rsel == 0) ? REF0 + b : (r.rsel == 1) ? REF0 + b + 5 : 32'hFFFF_FFFF;
      pi = {g ^ {15'd0, r.gbad}, r.app, rf};
      for (int i = 0; i < 8; i++) begin
        expb[q+i]   = pi[63-8*i -: 8];
        pm.mem[q+i] = ins ? ~expb[q+i] : expb[q+i];
      end
    end
  endtask

  task automatic run(input bmp_row_type r, input logic ins, input logic sl, input logic mid,
                     input logic wr);
    logic [31:0] fw;
    int          k;
    fw = {r.ml, 12'd8, 3'b000, r.sep, r.first, r.ty, 1'b1};
    build(r, ins && wr);
    len  <= 8'(2 * (8 + r.ml));
    slow <= sl;
    apb(1'b1, bmp_pkg::OFS_FORMAT, fw);
    apb(1'b1, bmp_pkg::OFS_APP_TAG, {r.mask, 16'h1234});
    apb(1'b1, bmp_pkg::OFS_REF_TAG, REF0);
    apb(1'b1, bmp_pkg::OFS_BLKCNT, 32'h0000_0002);
    go <= 1'b1;
    apb(1'b1, bmp_pkg::OFS_CMD, {23'd0, 1'b1, 3'b000, wr, ins, r.chk});
    check("in_ready", 32'd1, {31'd0, in_ready});
    if (mid) apb(1'b1, bmp_pkg::OFS_FORMAT, 32'h0000_0000);
    k = 0;
    while (busy !== 1'b0 && k < 500) begin
      @(posedge clk);
      k++;
    end
    check("busy", 32'd0, {31'd0, busy});
    repeat (2) @(posedge clk);
    check("err", {29'd0, r.exp}, {29'd0, err});
    check("count", {24'd0, len}, {24'd0, got});
    check("last", 32'd1, {31'd0, pm.capl[len-1]});
    for (int i = 0; i < 2 * (8 + r.ml); i++) begin
      check("byte", {24'd0, expb[i]}, {24'd0, pm.cap[i]});
      check("is_meta", {31'd0, expm[i] & r.sep}, {31'd0, pm.capm[i]});
    end
    apb(1'b0, bmp_pkg::OFS_STATUS, 32'h0000_0000);
    check("status", {28'd0, 1'b0, r.exp}, {28'd0, rd[3:0]});
    apb(1'b0, bmp_pkg::OFS_LAST_GUARD, 32'h0000_0000);
    check("last_guard", {16'd0, g_last}, rd);
    if (mid) apb(1'b0, bmp_pkg::OFS_FORMAT, 32'h0000_0000);
    if (mid) check("format", fw, rd);
    go <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: rows first, then insert, counters and refusal
  initial begin
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    go      = 1'b0;
    slow    = 1'b0;
    len     = 8'h00;
    repeat (2) @(posedge clk);
    check("reset", 32'd0, {26'd0, busy, pready, out_beat.valid, err});
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < NR; i++) run(rows[i], 1'b0, i[0], i == 2, 1'b1);
    run('{2'd1, 1'b1, 1'b0, 12'd8, 3'd0, 16'hFFFF, 16'h1234, 1'b0, 2'd0, 3'b000},
        1'b1, 1'b1, 1'b0, 1'b1);
    run('{2'd1, 1'b1, 1'b0, 12'd8, 3'd7, 16'hFFFF, 16'h1234, 1'b1, 2'd0, 3'b100},
        1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b0, bmp_pkg::OFS_BLKCNT, 32'h0000_0000);
    check("done_blocks", 32'd2, {16'd0, rd[31:16]});
    apb(1'b1, 8'h40, 32'h0000_0001);
    check("unmapped", 32'd1, {31'd0, rerr});
    final_report;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule // block_metadata_protection_info_tb
`default_nettype wire

/* testbench/bmp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host side: offers block bytes and collects what the engine passes on
module bmp_host_model (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_go,
  input  wire logic                  i_slow,
  input  wire logic [7:0]            i_len,
  input  wire logic                  i_in_ready,
  input  wire bmp_pkg::bmp_beat_type i_out,
  output bmp_pkg::bmp_beat_type      o_beat,
  output logic      [7:0]            o_got
);
  logic [7:0] mem [0:63];
  logic [7:0] cap [0:63];
  logic       capm [0:63];
  logic       capl [0:63];
  logic [7:0] sent;
  logic [7:0] n;
  logic       v;
  logic       tog;

  ////////////////////////////////////////////////////////////////////////////
  // Source holds a byte until taken; idle data flips so stale bytes never match
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_beat <= '0;
      sent   <= '0;
      tog    <= 1'b0;
    end else if (!i_go) begin
      sent         <= '0;
      o_beat.valid <= 1'b0;
      o_beat.data  <= ~o_beat.data;
    end else if (!o_beat.valid || i_in_ready) begin
      n = sent + 8'(o_beat.valid);
      v = (n < i_len) && !(i_slow && tog);
      sent         <= n;
      tog          <= ~tog;
      o_beat.valid <= v;
      o_beat.data  <= v ? mem[n] : ~o_beat.data;
    end
  end

  // Sink records every byte, its metadata flag and its end marker
  always @(posedge i_ref_clk) begin
    if (!i_go) begin
      o_got <= '0;
    end else if (i_out.valid) begin
      cap[o_got]  <= i_out.data;
      capm[o_got] <= i_out.is_meta;
      capl[o_got] <= i_out.last;
      o_got       <= o_got + 8'd1;
    end
  end
endmodule // bmp_host_model
`default_nettype wire
